// ==== core/vfcr_pkg.sv ====
// Purpose: shared constants of the video front end control registers
// Assumes: 200 MHz system clock, registers reached as 32-bit words
// Notes:   byte address of a register is four times its index
package vfcr_pkg;
   // register indices; a byte address is four times its index
   localparam logic [7:0] IDX_OFFSET  = 8'h1B;
   localparam logic [7:0] IDX_FILL    = 8'h1C;
   localparam logic [7:0] IDX_SLICER  = 8'h1D;
   localparam logic [7:0] IDX_INPWR   = 8'h1E;
   localparam logic [7:0] IDX_OUTPUT  = 8'h1F;
   localparam logic [7:0] IDX_STATUS  = 8'h24;
   localparam logic [7:0] IDX_PWRSTAT = 8'h26;
   localparam int         ADDR_W      = 8;
   // reset values
   localparam logic [7:0] RST_OFFSET  = 8'h18;
   localparam logic [7:0] RST_FILL    = 8'h00;
   localparam logic [7:0] RST_SLICER  = 8'h78;
   localparam logic [7:0] RST_INPWR   = 8'h20;
   localparam logic [6:0] RST_OUTPUT  = 7'h14;
   // offset control fields
   localparam int OFS_AUTO_BIT  = 5;
   localparam int OFS_RATE_LSB  = 3;
   // slicer control fields
   localparam int SLC_THR_LSB   = 3;
   localparam int SLC_POL_BIT   = 2;
   localparam int SLC_SEL_LSB   = 0;
   // input and power control fields
   localparam int IPC_OVR_BIT   = 7;
   localparam int IPC_CHSEL_BIT = 6;
   localparam int IPC_BW_BIT    = 5;
   localparam int IPC_AUTO_BIT  = 4;
   localparam int IPC_PD_BIT    = 3;
   localparam int IPC_PDPOL_BIT = 2;
   localparam int IPC_FAST_BIT  = 1;
   localparam int IPC_GZ_BIT    = 0;
   // output control fields
   localparam int OUT_MODE_LSB  = 5;
   localparam int OUT_PRI_BIT   = 4;
   localparam int OUT_SEC_BIT   = 3;
   localparam int OUT_DRV_LSB   = 1;
   localparam int OUT_CKINV_BIT = 0;
   // activity status fields
   localparam int STA_H0_BIT    = 7;
   localparam int STA_H1_BIT    = 6;
   localparam int STA_G0_BIT    = 3;
   localparam int STA_G1_BIT    = 2;
   // power status fields
   localparam int PST_DOWN_BIT  = 0;
   localparam int PST_REQ_BIT   = 1;
   localparam int PST_CH_BIT    = 2;
   // update rate codes and their period counts
   localparam logic [1:0] RATE_EACH   = 2'h0;
   localparam logic [1:0] RATE_16     = 2'h1;
   localparam logic [1:0] RATE_64     = 2'h2;
   localparam logic [1:0] RATE_VSYNC  = 2'h3;
   localparam logic [6:0] CNT_16      = 7'h10;
   localparam logic [6:0] CNT_64      = 7'h40;
   // sync-on-green output selection codes
   localparam logic [1:0] GSEL_SLICER = 2'h0;
   localparam logic [1:0] GSEL_HSYNC  = 2'h1;
   localparam logic [1:0] GSEL_REGEN  = 2'h2;
   localparam logic [1:0] GSEL_FILT   = 2'h3;
   // output mode codes
   localparam logic [1:0] MODE_RGB    = 2'h0;
   localparam logic [1:0] MODE_YCC    = 2'h1;
   localparam logic [1:0] MODE_DDR    = 2'h2;
   // activity observation window
   localparam int CLK_MHZ        = 200;
   localparam int ACT_WINDOW_US  = 100;
   localparam int ACT_WINDOW_CYC = ACT_WINDOW_US * CLK_MHZ;
endpackage

// ==== core/vfcr_tick_div.sv ====
// Purpose: divider that gives a one-cycle enable pulse every PERIOD cycles
// Assumes: PERIOD between 2 and 65535
// Notes:   the pulse marks the end of one activity window
`timescale 1ns/1ps
module vfcr_tick_div #(
   parameter int unsigned PERIOD = 16
) (
   input  wire logic clk,
   input  wire logic srst,
   output logic      tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } vfcr_div_s;

   vfcr_div_s st;
   vfcr_div_s next_st;

   // count down and pulse on wrap
   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      if (st.cnt == 16'h0000) begin
         next_st.cnt  = 16'(PERIOD - 1);
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt - 16'h0001;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule

// ==== core/vfcr_activity.sv ====
// Purpose: tells whether one sync input toggles within an observation window
// Assumes: level is synchronous to clk, tick is a one-cycle window pulse
// Notes:   a level held high or low reads inactive after one full window
`timescale 1ns/1ps
module vfcr_activity (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic tick,
   input  wire logic level,
   output logic      active
);
   typedef struct packed {
      logic armed;
      logic prev;
      logic seen;
      logic active;
   } vfcr_act_s;

   vfcr_act_s st;
   vfcr_act_s next_st;
   logic      edgeSeen;

   // any change of level is an edge; window end publishes and restarts
   // the first cycle after reset only learns the level, so a pin idling
   // high does not show a false edge
   always_comb begin
      edgeSeen      = st.armed & (level ^ st.prev);
      next_st       = st;
      next_st.prev  = level;
      next_st.armed = 1'b1;
      if (tick) begin
         next_st.active = st.seen | edgeSeen;
         next_st.seen   = edgeSeen;           // edge at window end is kept
      end else begin
         next_st.seen = st.seen | edgeSeen;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign active = st.active;
endmodule

// ==== core/vfcr_regs.sv ====
// Purpose: control registers of a video front end, Avalon-MM slave
// Assumes: all inputs synchronous to clk; internal syncs active high
// Notes:   each access takes two cycles: waitrequest high, then low
`timescale 1ns/1ps
module vfcr_regs
   import vfcr_pkg::*;
#(
   parameter int unsigned ACT_WINDOW_CYCLES = vfcr_pkg::ACT_WINDOW_CYC
) (
   input  wire logic                        clk,
   input  wire logic                        srst,
   input  wire logic [vfcr_pkg::ADDR_W-1:0] address,
   input  wire logic                        read,
   input  wire logic                        write,
   input  wire logic [31:0]                 writedata,
   input  wire logic [3:0]                  byteenable,
   output logic      [31:0]                 readdata,
   output logic                             waitrequest,
   input  wire logic                        horizontalSyncInputZero,
   input  wire logic                        horizontalSyncInputOne,
   input  wire logic                        syncOnGreenInputZero,
   input  wire logic                        syncOnGreenInputOne,
   input  wire logic                        powerDownPin,
   input  wire logic                        clampPulse,
   input  wire logic                        vsyncPulse,
   input  wire logic                        regenSync,
   input  wire logic                        filteredSync,
   output logic                             autoOffsetEn,
   output logic                             offsetUpdate,
   output logic      [4:0]                  slicerThreshold,
   output logic                             syncOnGreenOutPin,
   output logic                             syncOnGreenOutPinOe,
   output logic                             channelSel,
   output logic                             highBandwidth,
   output logic                             powerDown,
   output logic      [1:0]                  outputMode,
   output logic                             primaryOe,
   output logic                             secondaryOe,
   output logic      [1:0]                  driveStrength,
   output logic                             pixelClockInvert
);
   import vfcr_pkg::*;

   typedef struct packed {
      logic [7:0]  offsetCtl;
      logic [7:0]  testFill;
      logic [7:0]  slicerCtl;
      logic [7:0]  inPwrCtl;
      logic [6:0]  outCtl;
      logic        ack;
      logic [31:0] rdData;
      logic [6:0]  updCnt;
      logic        offsetUpdate;
      logic        autoChannel;
      logic        greenPin;
      logic        greenOe;
      logic        powerDown;
      logic        powerReq;
      logic        priOe;
      logic        secOe;
   } vfcr_main_s;

   vfcr_main_s st;
   vfcr_main_s next_st;

   logic       windowTick;
   logic [3:0] actBits;
   logic [3:0] syncLevels;
   logic       request;
   logic       aligned;
   logic [7:0] regIdx;
   logic [7:0] readByte;
   logic       mapped;
   logic       pinAsserted;
   logic       anyActive;
   logic       pdRequest;
   logic       chanInUse;
   logic [1:0] rate;
   logic       rateEvent;
   logic [6:0] rateLimit;
   logic       selSync;
   logic [1:0] mode;
   logic       dualMode;

   // one observation window shared by all activity detectors
   vfcr_tick_div #(
      .PERIOD (ACT_WINDOW_CYCLES)
   ) u_window (
      .clk  (clk),
      .srst (srst),
      .tick (windowTick)
   );

   // activity bits: horizontal_sync_input_zero, horizontal_sync_input_one, green0, green1
   assign syncLevels = {horizontalSyncInputZero, horizontalSyncInputOne,
                        syncOnGreenInputZero, syncOnGreenInputOne};

   for (genvar i = 0; i < 4; i++) begin : g_act
      vfcr_activity u_act (
         .clk    (clk),
         .srst   (srst),
         .tick   (windowTick),
         .level  (syncLevels[i]),
         .active (actBits[i])
      );
   end

   // bus decode: word aligned addresses only, index is address over four
   always_comb begin
      request = read | write;
      aligned = (address[1:0] == 2'h0);
      regIdx  = {2'h0, address[7:2]};
      mapped  = 1'b1;
      case (regIdx)
         IDX_OFFSET:  readByte = st.offsetCtl;
         IDX_FILL:    readByte = st.testFill;
         IDX_SLICER:  readByte = st.slicerCtl;
         IDX_INPWR:   readByte = st.inPwrCtl;
         IDX_OUTPUT:  readByte = {1'b0, st.outCtl};
         IDX_STATUS: begin
            readByte              = 8'h00;
            readByte[STA_H0_BIT] = actBits[3];
            readByte[STA_H1_BIT] = actBits[2];
            readByte[STA_G0_BIT] = actBits[1];
            readByte[STA_G1_BIT] = actBits[0];
         end
         IDX_PWRSTAT: begin
            readByte               = 8'h00;
            readByte[PST_DOWN_BIT] = st.powerDown;
            readByte[PST_REQ_BIT]  = st.powerReq;
            readByte[PST_CH_BIT]   = chanInUse;
         end
         default: begin
            readByte = 8'h00;
            mapped   = 1'b0;
         end
      endcase
      if (!aligned) begin
         readByte = 8'h00;
         mapped   = 1'b0;
      end
   end

   // power-down request: automatic from activity, manual from bit and pin
   always_comb begin
      pinAsserted = (powerDownPin == st.inPwrCtl[IPC_PDPOL_BIT]);
      anyActive   = |actBits;
      if (st.inPwrCtl[IPC_AUTO_BIT]) begin
         pdRequest = !anyActive;
      end else begin
         pdRequest = st.inPwrCtl[IPC_PD_BIT] | pinAsserted;
      end
   end

   // channel in use: user bit under override, device choice otherwise
   always_comb begin
      if (st.inPwrCtl[IPC_OVR_BIT]) begin
         chanInUse = st.inPwrCtl[IPC_CHSEL_BIT];
      end else begin
         chanInUse = st.autoChannel;
      end
   end

   // offset update event source and period count
   always_comb begin
      rate = st.offsetCtl[OFS_RATE_LSB +: 2];
      case (rate)
         RATE_EACH: begin
            rateEvent = clampPulse;
            rateLimit = 7'h01;
         end
         RATE_16: begin
            rateEvent = clampPulse;
            rateLimit = CNT_16;
         end
         RATE_64: begin
            rateEvent = clampPulse;
            rateLimit = CNT_64;
         end
         default: begin
            rateEvent = vsyncPulse;
            rateLimit = 7'h01;
         end
      endcase
   end

   // source for the sync-on-green pin; the slicer and hsync sources are taken from the channel in use
   always_comb begin
      case (st.slicerCtl[SLC_SEL_LSB +: 2])
         GSEL_SLICER: selSync = chanInUse ? syncOnGreenInputOne
                                          : syncOnGreenInputZero;
         GSEL_HSYNC:  selSync = chanInUse ? horizontalSyncInputOne
                                          : horizontalSyncInputZero;
         GSEL_REGEN:  selSync = regenSync;
         GSEL_FILT:   selSync = filteredSync;
         default:     selSync = 1'b0;
      endcase
   end

   // output mode decode: the secondary port exists in two modes only
   always_comb begin
      mode     = st.outCtl[OUT_MODE_LSB +: 2];
      dualMode = (mode == MODE_YCC) || (mode == MODE_DDR);
   end

   // next state of the whole block
   always_comb begin
      next_st = st;

      // handshake: take request, answer one cycle later
      next_st.ack = request & !st.ack;
      if (request && !st.ack) begin
         next_st.rdData = {24'h00_0000, read ? readByte : 8'h00};
      end

      // register writes land on the edge where waitrequest is low
      if (write && st.ack && mapped && byteenable[0]) begin
         case (regIdx)
            IDX_OFFSET: next_st.offsetCtl = writedata[7:0];
            IDX_FILL:   next_st.testFill  = writedata[7:0];
            IDX_SLICER: next_st.slicerCtl = writedata[7:0];
            IDX_INPWR:  next_st.inPwrCtl  = writedata[7:0];
            IDX_OUTPUT: next_st.outCtl    = writedata[6:0];
            default:    next_st.rdData    = st.rdData;      // read-only space
         endcase
      end

      // automatic channel choice follows the side that shows sync
      if (actBits[3] | actBits[1]) begin
         next_st.autoChannel = 1'b0;
      end else if (actBits[2] | actBits[0]) begin
         next_st.autoChannel = 1'b1;
      end

      // offset update pulse every chosen number of periods
      next_st.offsetUpdate = 1'b0;
      if (!st.offsetCtl[OFS_AUTO_BIT]) begin
         next_st.updCnt = 7'h00;
      end else if (rateEvent) begin
         if (st.updCnt + 7'h01 >= rateLimit) begin
            next_st.updCnt       = 7'h00;
            next_st.offsetUpdate = 1'b1;
         end else begin
            next_st.updCnt = st.updCnt + 7'h01;
         end
      end

      // power state: fast switching keeps power and only floats outputs
      next_st.powerReq  = pdRequest;
      next_st.powerDown = pdRequest & !st.inPwrCtl[IPC_FAST_BIT];
      next_st.priOe     = st.outCtl[OUT_PRI_BIT] & !pdRequest;
      next_st.secOe     = st.outCtl[OUT_SEC_BIT] & dualMode
                          & !pdRequest;

      // sync-on-green pin: polarity applied, floated in power-down if asked
      next_st.greenPin = st.slicerCtl[SLC_POL_BIT] ? selSync : !selSync;
      next_st.greenOe  = !(pdRequest & st.inPwrCtl[IPC_GZ_BIT]);
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st           <= '0;
         st.offsetCtl <= RST_OFFSET;
         st.testFill  <= RST_FILL;
         st.slicerCtl <= RST_SLICER;
         st.inPwrCtl  <= RST_INPWR;
         st.outCtl    <= RST_OUTPUT;
         st.greenOe   <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // bus answer
   assign waitrequest = request & !st.ack;
   assign readdata    = st.rdData;

   // control outputs straight from register fields, except offsetUpdate, the registered update pulse
   assign autoOffsetEn     = st.offsetCtl[OFS_AUTO_BIT];
   assign offsetUpdate     = st.offsetUpdate;
   assign slicerThreshold  = st.slicerCtl[SLC_THR_LSB +: 5];
   assign highBandwidth    = st.inPwrCtl[IPC_BW_BIT];
   assign outputMode       = mode;
   assign driveStrength    = st.outCtl[OUT_DRV_LSB +: 2];
   assign pixelClockInvert = st.outCtl[OUT_CKINV_BIT];

   // derived outputs, registered one cycle behind their causes, except channelSel, decoded straight from registers
   assign channelSel          = chanInUse;
   assign powerDown           = st.powerDown;
   assign primaryOe           = st.priOe;
   assign secondaryOe         = st.secOe;
   assign syncOnGreenOutPin   = st.greenPin;
   assign syncOnGreenOutPinOe = st.greenOe;
endmodule

// ==== verification/vfcr_regs_assertions.sv ====
// Purpose: port assertions for the video front end control registers
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every instance of the register block
`timescale 1ns/1ps
module vfcr_regs_assertions
   import vfcr_pkg::*;
#(
   parameter int unsigned ACT_WINDOW_CYCLES = vfcr_pkg::ACT_WINDOW_CYC
) (
   input wire logic                        clk,
   input wire logic                        srst,
   input wire logic [vfcr_pkg::ADDR_W-1:0] address,
   input wire logic                        read,
   input wire logic                        write,
   input wire logic [31:0]                 writedata,
   input wire logic [3:0]                  byteenable,
   input wire logic [31:0]                 readdata,
   input wire logic                        waitrequest,
   input wire logic                        clampPulse,
   input wire logic                        vsyncPulse,
   input wire logic                        autoOffsetEn,
   input wire logic                        offsetUpdate,
   input wire logic [4:0]                  slicerThreshold,
   input wire logic                        highBandwidth,
   input wire logic                        powerDown,
   input wire logic [1:0]                  outputMode,
   input wire logic                        primaryOe,
   input wire logic                        secondaryOe,
   input wire logic [1:0]                  driveStrength,
   input wire logic                        pixelClockInvert
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic wrOk;
   // accepted write with the low byte enabled
   assign wrOk = write && !waitrequest && byteenable[0];
   // bus handshake timing
   chk_wait_first: assert property (
      $rose(read || write) |-> waitrequest)
      else $error("waitrequest low in first request cycle");
   chk_wait_second: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest not low in second cycle");
   chk_read_upper: assert property (
      read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   // register fields follow accepted writes
   chk_auto_bit: assert property (
      wrOk && address == 8'h6C |=> autoOffsetEn == $past(writedata[5]))
      else $error("auto offset bit not taken from write");
   chk_thr_field: assert property (
      wrOk && address == 8'h74 |=> slicerThreshold == $past(writedata[7:3]))
      else $error("slicer threshold not taken from write");
   chk_band_bit: assert property (
      wrOk && address == 8'h78 |=> highBandwidth == $past(writedata[5]))
      else $error("bandwidth bit not taken from write");
   chk_out_fields: assert property (
      wrOk && address == 8'h7C |=> {outputMode, driveStrength, pixelClockInvert}
      == {$past(writedata[6:5]), $past(writedata[2:0])})
      else $error("output fields not taken from write");
   // derived outputs
   chk_upd_cause: assert property (
      offsetUpdate |-> $past(autoOffsetEn) && $past(clampPulse || vsyncPulse))
      else $error("offset update without cause");
   chk_pd_float: assert property (
      powerDown |-> !primaryOe && !secondaryOe)
      else $error("outputs driven while powered down");
   chk_sec_mode: assert property (
      secondaryOe |-> $past(outputMode) inside {2'h1, 2'h2})
      else $error("secondary output enabled in wrong mode");
endmodule

bind vfcr_regs vfcr_regs_assertions #(.ACT_WINDOW_CYCLES(ACT_WINDOW_CYCLES)) u_chk (
   .clk, .srst, .address, .read, .write, .writedata, .byteenable, .readdata,
   .waitrequest, .clampPulse, .vsyncPulse, .autoOffsetEn, .offsetUpdate,
   .slicerThreshold, .highBandwidth, .powerDown, .outputMode, .primaryOe,
   .secondaryOe, .driveStrength, .pixelClockInvert
);

// ==== verification/vfcr_host_bfm.sv ====
// Purpose: host software model issuing register bus cycles
// Assumes: slave stalls with waitrequest, one request at a time
// Notes:   signals change only just after a rising edge
`timescale 1ns/1ps
module vfcr_host_bfm (
   input  wire logic        clk,
   input  wire logic        waitrequest,
   input  wire logic [31:0] readdata,
   output logic      [7:0]  address,
   output logic             read,
   output logic             write,
   output logic      [31:0] writedata,
   output logic      [3:0]  byteenable
);
   // idle bus at time zero
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'hF;
   end
   // one transfer, held until waitrequest is sampled low at a rising edge;
   // read data is taken at that same edge, then the request is released
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      address <= a;
      writedata <= {24'h00_0000, d};
      write <= w;
      read <= !w;
      @(posedge clk);
      while (waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      if (a == 8'h7C && d[6:5] == 2'h3) d[6:5] = 2'h0;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 8'h00, q);
   endtask
   // settings software makes before use
   task automatic init();
      wr(8'h6C, 8'h13);
      wr(8'h70, 8'hFF);
      wr(8'h78, 8'h24);
   endtask
endmodule

// ==== verification/vfcr_regs_test.sv ====
// Purpose: self-checking bench of the control register block
// Assumes: 200 MHz clock, activity window shortened to 50 cycles
// Notes:   all bus traffic goes through the host model
`timescale 1ns/1ps
module vfcr_regs_test;
   import vfcr_pkg::*;
   localparam int WIN = 50;
   logic        clk = 1'b0, srst = 1'b1, toggle = 1'b0;
   logic [7:0]  address;
   logic        read, write, waitrequest;
   logic [31:0] writedata, readdata;
   logic [3:0]  byteenable;
   logic        horizontalSyncInputZero = 1'b0, horizontalSyncInputOne = 1'b0;
   logic        syncOnGreenInputZero = 1'b0, syncOnGreenInputOne = 1'b0;
   logic        powerDownPin = 1'b1, clampPulse = 1'b0, vsyncPulse = 1'b0;
   logic        regenSync = 1'b0, filteredSync = 1'b0;
   logic        autoOffsetEn, offsetUpdate, syncOnGreenOutPin, syncOnGreenOutPinOe;
   logic        channelSel, highBandwidth, powerDown, primaryOe, secondaryOe;
   logic        pixelClockInvert;
   logic [4:0]  slicerThreshold;
   logic [1:0]  outputMode, driveStrength;
   int          numErrors = 0, checkCount = 0;

   vfcr_regs #(.ACT_WINDOW_CYCLES(WIN)) dut (
      .clk, .srst, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .horizontalSyncInputZero, .horizontalSyncInputOne,
      .syncOnGreenInputZero, .syncOnGreenInputOne, .powerDownPin, .clampPulse,
      .vsyncPulse, .regenSync, .filteredSync, .autoOffsetEn, .offsetUpdate,
      .slicerThreshold, .syncOnGreenOutPin, .syncOnGreenOutPinOe, .channelSel,
      .highBandwidth, .powerDown, .outputMode, .primaryOe, .secondaryOe,
      .driveStrength, .pixelClockInvert
   );
   vfcr_host_bfm host (
      .clk, .waitrequest, .readdata, .address, .read, .write, .writedata, .byteenable
   );

   // clock and a free toggling sync source
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (toggle) horizontalSyncInputOne <= ~horizontalSyncInputOne;

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checkCount++;
      if (g !== e) begin
         numErrors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      host.rd(a, q);
      chk($sformatf("reg %h", a), {24'h00_0000, e}, q);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic testReset();
      rdchk(8'h6C, 8'h18);
      rdchk(8'h70, 8'h00);
      rdchk(8'h74, 8'h78);
      rdchk(8'h78, 8'h20);
      rdchk(8'h7C, 8'h14);
      chk("outputs", {5'h0F, 1'b1, 2'h0, 1'b1, 1'b0, 2'h2, 1'b0, 1'b0}, {slicerThreshold,
          highBandwidth, outputMode, primaryOe, secondaryOe, driveStrength,
          pixelClockInvert, autoOffsetEn});
   endtask
   task automatic testOutput();
      logic [7:0] cfg [3] = '{8'h2F, 8'h5F, 8'h18};
      logic [6:0] exp [3] = '{7'h2F, 7'h5F, 7'h10};
      powerDownPin <= 1'b0;
      host.init();
      rdchk(8'h6C, 8'h13);
      rdchk(8'h70, 8'hFF);
      for (int i = 0; i < 3; i++) begin
         host.wr(8'h7C, cfg[i]);
         rdchk(8'h7C, cfg[i]);
         settle(2);
         chk("output ctl", exp[i], {outputMode, primaryOe, secondaryOe, driveStrength,
             pixelClockInvert});
      end
      host.wr(8'h84, 8'hAA);
      rdchk(8'h84, 8'h00);
      rdchk(8'h6D, 8'h00);
   endtask
   task automatic upd(input logic clr, input logic [7:0] cfg, input logic v,
                      input int n, input int e);
      int cnt;
      cnt = 0;
      if (clr) begin
         host.wr(8'h6C, 8'h03);
         host.wr(8'h6C, cfg);
      end
      repeat (n + 2) begin
         @(posedge clk);
         clampPulse <= !v && n > 0;
         vsyncPulse <= v && n > 0;
         n--;
         #1 cnt += int'(offsetUpdate === 1'b1);
         @(posedge clk);
         clampPulse <= 1'b0;
         vsyncPulse <= 1'b0;
         #1 cnt += int'(offsetUpdate === 1'b1);
      end
      chk("updates", e, cnt);
   endtask
   task automatic testUpdate();
      upd(1'b1, 8'h23, 1'b0, 3, 3);
      upd(1'b1, 8'h2B, 1'b0, 15, 0);
      upd(1'b0, 8'h2B, 1'b0, 1, 1);
      upd(1'b1, 8'h33, 1'b0, 64, 1);
      upd(1'b1, 8'h3B, 1'b0, 5, 0);
      upd(1'b0, 8'h3B, 1'b1, 1, 1);
      upd(1'b1, 8'h03, 1'b0, 5, 0);
   endtask
   task automatic testSog();
      host.wr(8'h78, 8'hA4);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         syncOnGreenInputZero <= (s == 0);
         horizontalSyncInputZero <= (s == 1);
         regenSync <= (s == 2);
         filteredSync <= (s == 3);
         host.wr(8'h74, {5'h0F, 1'b1, 2'(s)});
         settle(3);
         chk("green pin", 2'h3, {syncOnGreenOutPinOe, syncOnGreenOutPin});
      end
      host.wr(8'h74, 8'h7B);
      settle(3);
      chk("green polarity", 1'b0, syncOnGreenOutPin);
      filteredSync <= 1'b0;
      syncOnGreenInputOne <= 1'b1;
      host.wr(8'h78, 8'hE4);
      host.wr(8'h74, 8'h7C);
      settle(3);
      chk("channel one", 2'h3, {channelSel, syncOnGreenOutPin});
   endtask
   task automatic testPower();
      logic [11:0] tp [7] = '{12'h243, 12'h2C5, 12'h2D4, 12'h2F0, 12'h24D, 12'h20B,
                              12'h205};
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         powerDownPin <= tp[i][3];
         host.wr(8'h78, tp[i][11:4]);
         settle(3);
         chk("power", tp[i][2:0],
             {powerDown, primaryOe, syncOnGreenOutPinOe});
      end
   endtask
   task automatic testAuto();
      host.wr(8'h78, 8'h3C);
      settle(3 * WIN);
      chk("auto down", 1'b1, powerDown);
      @(posedge clk);
      toggle <= 1'b1;
      settle(3 * WIN);
      chk("auto up", 1'b0, powerDown);
      rdchk(8'h90, 8'h40);
      rdchk(8'h98, 8'h04);
      toggle <= 1'b0;
      settle(3 * WIN);
      rdchk(8'h90, 8'h00);
      chk("auto idle", 1'b1, powerDown);
   endtask
   task automatic finishTest();
      $display("checks %0d errors %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      testReset();
      testOutput();
      testUpdate();
      testSog();
      testPower();
      testAuto();
      finishTest();
   end
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      numErrors++;
      finishTest();
   end
endmodule
